// ==== ipc_bus_partner.sv ====
// Pad-side model of the external bus parties on the pins
`timescale 1ns/1ps
module ipc_bus_partner #(
   parameter int PIN_N = 42
) (
   input wire logic clk,
   input wire logic [PIN_N-1:0] pinOut,
   input wire logic [PIN_N-1:0] pinOe,
   output logic [PIN_N-1:0] padLevel
);
   initial padLevel = '0;
   // Undriven pads toggle so a floated pin never passes for a steady level
   always @(posedge clk) begin
      for (int i = 0; i < PIN_N; i++) begin
         padLevel[i] <= pinOe[i] ? pinOut[i] : ~padLevel[i];
      end
   end
endmodule : ipc_bus_partner

// ==== ipc_io_pin_state_control.sv ====
// Per-pin output state selection by operating mode, processing state and enables
`timescale 1ns/1ps
`include "ipc_regs.svh"

module ipc_io_pin_state_control #(
   parameter int LOW_ADDR_W = `IPC_LOW_ADDR_W,
   parameter int PIN_N = `IPC_PIN_LOWADDR + LOW_ADDR_W + `IPC_OFS_COUNT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`IPC_MODE_W-1:0] mode,
   input wire ipc_pkg::ipc_proc_e procState,
   input wire ipc_pkg::ipc_cfg_s cfg,
   input wire logic [PIN_N-1:0] gpioDir,
   input wire logic [PIN_N-1:0] gpioOut,
   input wire logic [PIN_N-1:0] funcOut,
   output logic [PIN_N-1:0] pinOut,
   output logic [PIN_N-1:0] pinOe
);

   localparam int TAIL = `IPC_PIN_LOWADDR + LOW_ADDR_W;
   localparam int PIN_CLOCK = TAIL + `IPC_OFS_CLOCK;
   localparam int PIN_LOWWR = TAIL + `IPC_OFS_LOWWR;
   localparam int PIN_COLSTB = TAIL + `IPC_OFS_COLSTB;
   localparam int PIN_CS0 = TAIL + `IPC_OFS_CS0;
   localparam int PIN_ADSTB = TAIL + `IPC_OFS_ADSTB;
   localparam int PIN_RDSTB = TAIL + `IPC_OFS_RDSTB;
   localparam int PIN_HIWR = TAIL + `IPC_OFS_HIWR;
   localparam int PIN_BUSACK = TAIL + `IPC_OFS_BUSACK;
   localparam int PIN_BUSREQ = TAIL + `IPC_OFS_BUSREQ;

   ipc_pkg::ipc_role_e [PIN_N-1:0] role;

   // Selects the role for the present processing state; sleep behaves as execution
   function automatic ipc_pkg::ipc_role_e pick(
      input ipc_pkg::ipc_proc_e ps,
      input ipc_pkg::ipc_role_e inReset,
      input ipc_pkg::ipc_role_e inSwStby,
      input ipc_pkg::ipc_role_e inRelease,
      input ipc_pkg::ipc_role_e inExec
   );
      ipc_pkg::ipc_role_e r;
      r = ipc_pkg::ROLE_FLOAT;
      unique case (ps)
         ipc_pkg::PS_RESET: r = inReset;
         ipc_pkg::PS_HW_STANDBY: r = ipc_pkg::ROLE_FLOAT;
         ipc_pkg::PS_SW_STANDBY: r = inSwStby;
         ipc_pkg::PS_BUS_RELEASED: r = inRelease;
         ipc_pkg::PS_EXEC, ipc_pkg::PS_SLEEP: r = inExec;
         default: r = ipc_pkg::ROLE_FLOAT;
      endcase
      return r;
   endfunction : pick

   // Standby treatment of a bus output: driven idle-high or floated
   function automatic ipc_pkg::ipc_role_e stbyHigh(input logic hold);
      return hold ? ipc_pkg::ROLE_HIGH : ipc_pkg::ROLE_FLOAT;
   endfunction : stbyHigh

   // Standby treatment of an address output: last level kept or floated
   function automatic ipc_pkg::ipc_role_e stbyKeep(input logic hold);
      return hold ? ipc_pkg::ROLE_HOLD : ipc_pkg::ROLE_FLOAT;
   endfunction : stbyKeep

   // Chip-select pin of either group
   function automatic ipc_pkg::ipc_role_e csRole(
      input ipc_pkg::ipc_proc_e ps,
      input logic en,
      input logic dir,
      input logic hold
   );
      ipc_pkg::ipc_role_e r;
      r = ipc_pkg::ROLE_FLOAT;
      if (!en) begin
         r = pick(ps, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                  ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
      end else if (!dir) begin
         r = pick(ps, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                  ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_INPUT);
      end else begin
         r = pick(ps, ipc_pkg::ROLE_FLOAT, stbyHigh(hold),
                  ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
      end
      return r;
   endfunction : csRole

   logic busMode;
   logic bus45;
   logic mode6;
   logic hold;
   logic reqAtP5;
   logic reqAtPf;
   logic waitAtP5;
   logic waitAtPf;
   logic lowerColEn;

   always_comb begin
      busMode = (mode == `IPC_MODE_4) || (mode == `IPC_MODE_5) || (mode == `IPC_MODE_6);
      bus45 = (mode == `IPC_MODE_4) || (mode == `IPC_MODE_5);
      mode6 = (mode == `IPC_MODE_6);
      hold = cfg.standbyOutputHold;
      // Route bit set sends the function to port 5, clear sends it to port F
      reqAtP5 = cfg.busRequestOutEnable & cfg.busRequestOutRoute;
      reqAtPf = cfg.busRequestOutEnable & ~cfg.busRequestOutRoute;
      waitAtP5 = cfg.waitInputEnable & cfg.waitPinRoute;
      waitAtPf = cfg.waitInputEnable & ~cfg.waitPinRoute;
      lowerColEn = cfg.dramSpaceEnable & cfg.dramAccess16;
   end

   always_comb begin
      // Mode 7 and the undefined modes leave every pin except the clock pin to the port logic
      for (int i = 0; i < PIN_N; i++) begin
         role[i] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                        ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
      end

      // Clock pin follows its direction bit in every mode
      if (gpioDir[PIN_CLOCK]) begin
         role[PIN_CLOCK] = pick(procState,
                                busMode ? ipc_pkg::ROLE_FUNC_OUT : ipc_pkg::ROLE_FLOAT,
                                ipc_pkg::ROLE_HIGH, ipc_pkg::ROLE_FUNC_OUT,
                                ipc_pkg::ROLE_FUNC_OUT);
      end else begin
         role[PIN_CLOCK] = pick(procState,
                                busMode ? ipc_pkg::ROLE_FUNC_OUT : ipc_pkg::ROLE_FLOAT,
                                ipc_pkg::ROLE_INPUT, ipc_pkg::ROLE_INPUT,
                                ipc_pkg::ROLE_INPUT);
      end

      if (busMode) begin
         // Port 5 wait/request pin
         if (reqAtP5) begin
            role[`IPC_PIN_WAITREQ] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                          ipc_pkg::ROLE_FUNC_OUT, ipc_pkg::ROLE_FUNC_OUT);
         end else if (waitAtP5 && !gpioDir[`IPC_PIN_WAITREQ]) begin
            role[`IPC_PIN_WAITREQ] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FLOAT,
                                          ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_IN);
         end else begin
            role[`IPC_PIN_WAITREQ] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                          ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
         end

         // Port F shared pin: lower column strobe outranks request and wait
         if (lowerColEn) begin
            role[`IPC_PIN_STROBE_MUX] = pick(procState, ipc_pkg::ROLE_FLOAT, stbyHigh(hold),
                                             ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
         end else if (reqAtPf) begin
            role[`IPC_PIN_STROBE_MUX] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                             ipc_pkg::ROLE_FUNC_OUT, ipc_pkg::ROLE_FUNC_OUT);
         end else if (waitAtPf && !gpioDir[`IPC_PIN_STROBE_MUX]) begin
            role[`IPC_PIN_STROBE_MUX] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FLOAT,
                                             ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_IN);
         end else begin
            role[`IPC_PIN_STROBE_MUX] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                             ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
         end

         // Chip selects; enables must only change with direction clear, else a glitch is possible
         for (int k = 0; k < `IPC_P6_PAIR; k++) begin
            role[`IPC_PIN_CSA_P6 + k] = csRole(procState, cfg.chipSelectGroupAEnable,
                                               gpioDir[`IPC_PIN_CSA_P6 + k], hold);
            role[`IPC_PIN_CSB_P6 + k] = csRole(procState, cfg.chipSelectGroupBEnable,
                                               gpioDir[`IPC_PIN_CSB_P6 + k], hold);
         end
         role[`IPC_PIN_CSA_PG] = csRole(procState, cfg.chipSelectGroupAEnable,
                                        gpioDir[`IPC_PIN_CSA_PG], hold);
         for (int k = 0; k < `IPC_PG_B_PAIR; k++) begin
            role[`IPC_PIN_CSB_PG + k] = csRole(procState, cfg.chipSelectGroupBEnable,
                                               gpioDir[`IPC_PIN_CSB_PG + k], hold);
         end

         // Upper address bits, one enable each
         for (int k = 0; k < `IPC_UPPER_ADDR_N; k++) begin
            if (!cfg.upperAddrEnable[k]) begin
               role[`IPC_PIN_UPPER + k] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                               ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
            end else if (!gpioDir[`IPC_PIN_UPPER + k]) begin
               role[`IPC_PIN_UPPER + k] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FLOAT,
                                               ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_INPUT);
            end else begin
               role[`IPC_PIN_UPPER + k] = pick(procState, ipc_pkg::ROLE_FLOAT, stbyKeep(hold),
                                               ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
            end
         end

         // Address bit 20
         if (bus45) begin
            if (!cfg.addr20Enable && gpioDir[`IPC_PIN_ADDR20]) begin
               role[`IPC_PIN_ADDR20] = pick(procState, ipc_pkg::ROLE_LOW, ipc_pkg::ROLE_HOLD,
                                            ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
            end else begin
               role[`IPC_PIN_ADDR20] = pick(procState, ipc_pkg::ROLE_LOW, stbyKeep(hold),
                                            ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
            end
         end else if (cfg.addr20Enable && gpioDir[`IPC_PIN_ADDR20]) begin
            role[`IPC_PIN_ADDR20] = pick(procState, ipc_pkg::ROLE_FLOAT, stbyKeep(hold),
                                         ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
         end else begin
            role[`IPC_PIN_ADDR20] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                         ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
         end

         // Lower address bits of ports A, B and C
         for (int k = 0; k < LOW_ADDR_W; k++) begin
            if (bus45) begin
               role[`IPC_PIN_LOWADDR + k] = pick(procState, ipc_pkg::ROLE_LOW, stbyKeep(hold),
                                                 ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
            end else if (gpioDir[`IPC_PIN_LOWADDR + k]) begin
               role[`IPC_PIN_LOWADDR + k] = pick(procState, ipc_pkg::ROLE_FLOAT, stbyKeep(hold),
                                                 ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
            end else begin
               role[`IPC_PIN_LOWADDR + k] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FLOAT,
                                                 ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_INPUT);
            end
         end

         // Low-byte write strobe
         if (cfg.lowWriteOff) begin
            role[PIN_LOWWR] = pick(procState, ipc_pkg::ROLE_HIGH, ipc_pkg::ROLE_HOLD,
                                   ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
         end else begin
            role[PIN_LOWWR] = pick(procState, ipc_pkg::ROLE_HIGH, stbyHigh(hold),
                                   ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
         end

         // Address strobe has the same shape as the low write strobe
         if (cfg.addrStrobeOff) begin
            role[PIN_ADSTB] = pick(procState, ipc_pkg::ROLE_HIGH, ipc_pkg::ROLE_HOLD,
                                   ipc_pkg::ROLE_HOLD, ipc_pkg::ROLE_GPIO);
         end else begin
            role[PIN_ADSTB] = pick(procState, ipc_pkg::ROLE_HIGH, stbyHigh(hold),
                                   ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
         end

         role[PIN_RDSTB] = pick(procState, ipc_pkg::ROLE_HIGH, stbyHigh(hold),
                                ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
         role[PIN_HIWR] = pick(procState, ipc_pkg::ROLE_HIGH, stbyHigh(hold),
                               ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);

         // Column strobe keeps running in standby only with standbyOutputHold set, so refresh can continue
         if (cfg.dramSpaceEnable) begin
            role[PIN_COLSTB] = pick(procState, ipc_pkg::ROLE_FLOAT,
                                    hold ? ipc_pkg::ROLE_FUNC_OUT : ipc_pkg::ROLE_FLOAT,
                                    ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
         end else begin
            role[PIN_COLSTB] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                    ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_INPUT);
         end

         // Chip select 0 idles high through reset in modes 4 and 5
         if (gpioDir[PIN_CS0]) begin
            role[PIN_CS0] = pick(procState, bus45 ? ipc_pkg::ROLE_HIGH : ipc_pkg::ROLE_FLOAT,
                                 stbyHigh(hold), ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT);
         end else begin
            role[PIN_CS0] = pick(procState, bus45 ? ipc_pkg::ROLE_HIGH : ipc_pkg::ROLE_FLOAT,
                                 ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_INPUT);
         end

         // Bus release handshake pins
         if (cfg.busReleaseEnable) begin
            role[PIN_BUSACK] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_OUT,
                                    ipc_pkg::ROLE_LOW, ipc_pkg::ROLE_FUNC_OUT);
            role[PIN_BUSREQ] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FLOAT,
                                    ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_FUNC_IN);
         end else begin
            role[PIN_BUSACK] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                    ipc_pkg::ROLE_LOW, ipc_pkg::ROLE_GPIO);
            role[PIN_BUSREQ] = pick(procState, ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_HOLD,
                                    ipc_pkg::ROLE_FLOAT, ipc_pkg::ROLE_GPIO);
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < PIN_N; g++) begin : gPin
         ipc_pin_cell uCell (
            .clk(clk),
            .rst(rst),
            .role(role[g]),
            .gpioDir(gpioDir[g]),
            .gpioOut(gpioOut[g]),
            .funcOut(funcOut[g]),
            .pinOut(pinOut[g]),
            .pinOe(pinOe[g])
         );
      end
   endgenerate

endmodule : ipc_io_pin_state_control

// ==== ipc_io_pin_state_control_props.sv ====
// Concurrent checks on the pin state control outputs
`timescale 1ns/1ps
module ipc_io_pin_state_control_props #(
   parameter int LOW_ADDR_W = 20,
   parameter int PIN_N = 42
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] mode,
   input wire ipc_pkg::ipc_proc_e procState,
   input wire ipc_pkg::ipc_cfg_s cfg,
   input wire logic [PIN_N-1:0] gpioDir,
   input wire logic [PIN_N-1:0] gpioOut,
   input wire logic [PIN_N-1:0] funcOut,
   input wire logic [PIN_N-1:0] pinOut,
   input wire logic [PIN_N-1:0] pinOe
);
   logic bus46;
   assign bus46 = mode >= 3'h4 && mode <= 3'h6;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence swStby46;
      bus46 && procState == ipc_pkg::PS_SW_STANDBY;
   endsequence
   chk_hw_float: assert property (procState == ipc_pkg::PS_HW_STANDBY |=> pinOe == '0)
      else $error("pin driven in hardware standby");
   chk_m7_reset: assert property (mode == 3'h7 && procState == ipc_pkg::PS_RESET |=> pinOe == '0)
      else $error("mode 7 pin driven in reset");
   chk_m7_gpio: assert property (mode == 3'h7 && procState == ipc_pkg::PS_EXEC |=>
      pinOe[32:13] == $past(gpioDir[32:13]) && pinOut[32:13] == $past(gpioOut[32:13]))
      else $error("mode 7 port not following port bits");
   // Clock pin left out: it goes high in standby even in mode 7
   chk_m7_hold: assert property (mode == 3'h7 && procState inside {ipc_pkg::PS_SW_STANDBY,
      ipc_pkg::PS_BUS_RELEASED} |=> $stable(pinOe[32:0]) && $stable(pinOut[32:0]))
      else $error("held pins changed");
   chk_addr_rst_low: assert property (mode inside {3'h4, 3'h5} && procState == ipc_pkg::PS_RESET
      |=> &pinOe[32:13] && pinOut[32:13] == '0) else $error("address pins not low in reset");
   chk_m6_addr_dir: assert property (mode == 3'h6 && procState == ipc_pkg::PS_EXEC
      |=> pinOe[32:13] == $past(gpioDir[32:13])) else $error("mode 6 address drive wrong");
   chk_addr_rel_float: assert property (mode == 3'h6 && procState == ipc_pkg::PS_BUS_RELEASED
      |=> pinOe[32:13] == '0) else $error("address driven while released");
   chk_clk_stby_high: assert property (swStby46 ##0 gpioDir[33] |=> pinOe[33] && pinOut[33])
      else $error("clock pin not high in standby");
   chk_lower_column_strobe_stby: assert property (swStby46 ##0 (cfg.dramSpaceEnable && cfg.dramAccess16)
      |=> pinOe[1] == $past(cfg.standbyOutputHold) && (pinOut[1] || !pinOe[1]))
      else $error("lower column strobe standby wrong");
   chk_csa_stby: assert property (swStby46 ##0 (cfg.chipSelectGroupAEnable && gpioDir[2])
      |=> pinOe[2] == $past(cfg.standbyOutputHold) && (pinOut[2] || !pinOe[2]))
      else $error("chip select standby wrong");
   chk_colstb_rel: assert property (bus46 && procState == ipc_pkg::PS_BUS_RELEASED |=> !pinOe[35])
      else $error("column strobe driven while released");
endmodule : ipc_io_pin_state_control_props
bind ipc_io_pin_state_control ipc_io_pin_state_control_props #(.LOW_ADDR_W(LOW_ADDR_W), .PIN_N(PIN_N)) u_props (
   .clk(clk), .rst(rst), .mode(mode), .procState(procState), .cfg(cfg), .gpioDir(gpioDir),
   .gpioOut(gpioOut), .funcOut(funcOut), .pinOut(pinOut), .pinOe(pinOe));

// ==== ipc_pin_cell.sv ====
// One pad driver: turns a pin role into registered drive level and enable
`timescale 1ns/1ps
`include "ipc_regs.svh"

module ipc_pin_cell (
   input wire logic clk,
   input wire logic rst,
   input wire ipc_pkg::ipc_role_e role,
   input wire logic gpioDir,
   input wire logic gpioOut,
   input wire logic funcOut,
   output logic pinOut,
   output logic pinOe
);

   ipc_pkg::ipc_pin_s state;
   ipc_pkg::ipc_pin_s next_state;

   always_comb begin
      next_state = state;
      unique case (role)
         ipc_pkg::ROLE_FLOAT: begin
            next_state.oe = 1'h0;
         end
         // An input was not driving, so it stays floated; an output keeps its level
         ipc_pkg::ROLE_HOLD: begin
            next_state = state;
         end
         ipc_pkg::ROLE_HIGH: begin
            next_state.oe = 1'h1;
            next_state.out = 1'h1;
         end
         ipc_pkg::ROLE_LOW: begin
            next_state.oe = 1'h1;
            next_state.out = 1'h0;
         end
         ipc_pkg::ROLE_GPIO: begin
            next_state.oe = gpioDir;
            next_state.out = gpioOut;
         end
         ipc_pkg::ROLE_INPUT, ipc_pkg::ROLE_FUNC_IN: begin
            next_state.oe = 1'h0;
         end
         ipc_pkg::ROLE_FUNC_OUT: begin
            next_state.oe = 1'h1;
            next_state.out = funcOut;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state.oe <= `IPC_RST_OE;
         state.out <= `IPC_RST_OUT;
      end else begin
         state <= next_state;
      end
   end

   assign pinOut = state.out;
   assign pinOe = state.oe;

endmodule : ipc_pin_cell

// ==== ipc_pkg.sv ====
// Types shared by the I/O pin state control block
package ipc_pkg;

   typedef enum logic [2:0] {
      PS_RESET,
      PS_HW_STANDBY,
      PS_SW_STANDBY,
      PS_BUS_RELEASED,
      PS_EXEC,
      PS_SLEEP
   } ipc_proc_e;

   typedef enum logic [2:0] {
      ROLE_FLOAT,
      ROLE_HOLD,
      ROLE_HIGH,
      ROLE_LOW,
      ROLE_GPIO,
      ROLE_INPUT,
      ROLE_FUNC_OUT,
      ROLE_FUNC_IN
   } ipc_role_e;

   typedef struct packed {
      logic waitInputEnable;
      logic waitPinRoute;
      logic busReleaseEnable;
      logic busRequestOutEnable;
      logic busRequestOutRoute;
      logic dramSpaceEnable;
      logic dramAccess16;
      logic [2:0] upperAddrEnable;
      logic addr20Enable;
      logic addrStrobeOff;
      logic chipSelectGroupAEnable;
      logic chipSelectGroupBEnable;
      logic lowWriteOff;
      logic standbyOutputHold;
   } ipc_cfg_s;

   typedef struct packed {
      logic oe;
      logic out;
   } ipc_pin_s;

endpackage : ipc_pkg

// ==== ipc_regs.svh ====
// Constants for the I/O pin state control block
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH

`define IPC_MODE_W 3
`define IPC_MODE_4 3'h4
`define IPC_MODE_5 3'h5
`define IPC_MODE_6 3'h6
`define IPC_MODE_7 3'h7

`define IPC_LOW_ADDR_W 20
`define IPC_UPPER_ADDR_N 3

`define IPC_PIN_WAITREQ 0
`define IPC_PIN_STROBE_MUX 1
`define IPC_PIN_CSA_P6 2
`define IPC_PIN_CSB_P6 4
`define IPC_PIN_CSA_PG 6
`define IPC_PIN_CSB_PG 7
`define IPC_PIN_UPPER 9
`define IPC_PIN_ADDR20 12
`define IPC_PIN_LOWADDR 13

`define IPC_OFS_CLOCK 0
`define IPC_OFS_LOWWR 1
`define IPC_OFS_COLSTB 2
`define IPC_OFS_CS0 3
`define IPC_OFS_ADSTB 4
`define IPC_OFS_RDSTB 5
`define IPC_OFS_HIWR 6
`define IPC_OFS_BUSACK 7
`define IPC_OFS_BUSREQ 8
`define IPC_OFS_COUNT 9

`define IPC_P6_PAIR 2
`define IPC_PG_B_PAIR 2

`define IPC_RST_OE 1'h0
`define IPC_RST_OUT 1'h0

`endif

// ==== test_io_pin_state_control.sv ====
// Self-checking bench for the pin state control block
`timescale 1ns/1ps
module test_io_pin_state_control;
   localparam logic [41:0] laMask = 42'h1_FFFF_E000;
   localparam logic [41:0] ckMask = 42'h2_0000_0000;
   localparam logic [41:0] csMask = 42'h0_0000_0014;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [2:0] mode = 3'h7;
   ipc_pkg::ipc_proc_e ps = ipc_pkg::PS_RESET;
   ipc_pkg::ipc_cfg_s cfg = '0;
   logic [41:0] gpioDir = '0;
   logic [41:0] gpioOut = '0;
   logic [41:0] funcOut = '0;
   logic [41:0] pinOut;
   logic [41:0] pinOe;
   logic [41:0] padLevel;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   ipc_io_pin_state_control DUT (.clk(clk), .rst(rst), .mode(mode), .procState(ps), .cfg(cfg),
      .gpioDir(gpioDir), .gpioOut(gpioOut), .funcOut(funcOut), .pinOut(pinOut), .pinOe(pinOe));
   ipc_bus_partner partner (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel));
   always #12.5 clk = ~clk;
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // The whole run needs about 35 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic check(input logic [41:0] seen, input logic [41:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic go(input logic [2:0] m, input ipc_pkg::ipc_proc_e p);
      mode = m;
      ps = p;
      @(posedge clk);
      #2;
   endtask : go
   task automatic t_reset4;
      funcOut = ckMask;
      go(3'h4, ipc_pkg::PS_RESET);
      check(pinOe & laMask, laMask);
      check(pinOut & laMask, '0);
      check(pinOe & pinOut & ckMask, ckMask);
   endtask : t_reset4
   task automatic t_addr6;
      gpioDir = 42'h0_AAAA_A000;
      funcOut = laMask;
      go(3'h6, ipc_pkg::PS_EXEC);
      check(pinOe & laMask, gpioDir & laMask);
      check(pinOut & gpioDir, gpioDir);
      funcOut = '0;
      cfg.standbyOutputHold = 1'h1;
      go(3'h6, ipc_pkg::PS_SW_STANDBY);
      check(pinOe & pinOut & laMask, gpioDir);
      cfg.standbyOutputHold = 1'h0;
      go(3'h6, ipc_pkg::PS_SW_STANDBY);
      check(pinOe & laMask, '0);
      go(3'h6, ipc_pkg::PS_BUS_RELEASED);
      check(pinOe & (laMask | 42'h8_0000_0000), '0);
   endtask : t_addr6
   task automatic t_hwstby;
      for (int m = 4; m < 8; m++) begin
         go(3'(m), ipc_pkg::PS_HW_STANDBY);
         check(pinOe, '0);
      end
   endtask : t_hwstby
   task automatic t_mode7;
      cfg = '0;
      gpioDir = 42'h3FF;
      gpioOut = 42'h155;
      go(3'h7, ipc_pkg::PS_RESET);
      check(pinOe, '0);
      go(3'h7, ipc_pkg::PS_EXEC);
      check(pinOe & 42'h3FF, 42'h3FF);
      gpioOut = '0;
      go(3'h7, ipc_pkg::PS_SW_STANDBY);
      check(pinOut & 42'h3FF, 42'h155);
      go(3'h7, ipc_pkg::PS_BUS_RELEASED);
      check(padLevel & 42'h3FF, 42'h155);
   endtask : t_mode7
   task automatic t_chipsel;
      gpioDir = csMask;
      gpioOut = csMask;
      go(3'h5, ipc_pkg::PS_EXEC);
      check(pinOe & pinOut & csMask, csMask);
      gpioDir = '0;
      go(3'h5, ipc_pkg::PS_EXEC);
      // Group enables move only while the direction bits are clear
      cfg.chipSelectGroupAEnable = 1'h1;
      cfg.chipSelectGroupBEnable = 1'h1;
      go(3'h5, ipc_pkg::PS_EXEC);
      check(pinOe & csMask, '0);
      gpioDir = csMask;
      go(3'h5, ipc_pkg::PS_EXEC);
      check(pinOe & ~pinOut & csMask, csMask);
      cfg.standbyOutputHold = 1'h1;
      go(3'h5, ipc_pkg::PS_SW_STANDBY);
      check(pinOe & pinOut & csMask, csMask);
      cfg.standbyOutputHold = 1'h0;
      go(3'h5, ipc_pkg::PS_SW_STANDBY);
      check(pinOe & csMask, '0);
   endtask : t_chipsel
   task automatic t_lower_column_strobe;
      cfg.dramSpaceEnable = 1'h1;
      cfg.dramAccess16 = 1'h1;
      gpioDir = ckMask;
      funcOut = 42'h2;
      go(3'h4, ipc_pkg::PS_EXEC);
      check(pinOe & pinOut & 42'h2, 42'h2);
      go(3'h4, ipc_pkg::PS_BUS_RELEASED);
      check(pinOe & 42'h2, '0);
      funcOut = '0;
      cfg.standbyOutputHold = 1'h1;
      go(3'h4, ipc_pkg::PS_SW_STANDBY);
      check(pinOe & pinOut & (ckMask | 42'h2), ckMask | 42'h2);
   endtask : t_lower_column_strobe
   task automatic t_ctrl;
      cfg = '0;
      cfg.waitInputEnable = 1'h1;
      cfg.waitPinRoute = 1'h1;
      cfg.upperAddrEnable = 3'h5;
      cfg.lowWriteOff = 1'h1;
      cfg.standbyOutputHold = 1'h1;
      gpioDir = 42'h4_0000_1606;
      gpioOut = 42'h4_0000_1406;
      funcOut = 42'h0_0000_0200;
      go(3'h5, ipc_pkg::PS_EXEC);
      check(pinOe & pinOut & 42'h4_0000_1E07, 42'h4_0000_1606);
      // Port data cleared so a held pin is told apart from one still following it
      gpioOut = '0;
      go(3'h5, ipc_pkg::PS_SW_STANDBY);
      check(pinOe & pinOut & 42'h4_0000_1E07, 42'h4_0000_1606);
      go(3'h5, ipc_pkg::PS_BUS_RELEASED);
      check(pinOe & pinOut & 42'h4_0000_1E07, 42'h4_0000_1406);
      cfg.waitInputEnable = 1'h0;
      cfg.addr20Enable = 1'h1;
      cfg.standbyOutputHold = 1'h0;
      gpioDir = 42'h4_0000_1607;
      gpioOut = 42'h0_0000_0001;
      funcOut = 42'h0_0000_1000;
      go(3'h6, ipc_pkg::PS_EXEC);
      check(pinOe & pinOut & 42'h0_0000_1201, 42'h0_0000_1001);
      gpioOut = '0;
      go(3'h6, ipc_pkg::PS_SW_STANDBY);
      check(pinOe & 42'h0_0000_1201, 42'h0_0000_0001);
      check(pinOut & 42'h0_0000_0001, 42'h0_0000_0001);
      go(3'h6, ipc_pkg::PS_SLEEP);
      check(pinOe & 42'h0_0000_1201, 42'h0_0000_1201);
      go(3'h6, ipc_pkg::PS_BUS_RELEASED);
      check(pinOe & 42'h0_0000_1201, 42'h0_0000_0001);
   endtask : t_ctrl
   initial begin
      repeat (6) @(posedge clk);
      #2;
      rst = 1'h0;
      t_reset4();
      t_addr6();
      t_hwstby();
      t_mode7();
      t_chipsel();
      t_lower_column_strobe();
      t_ctrl();
      end_of_test();
   end
endmodule : test_io_pin_state_control
